// File: hw/tcch_defines.vh
// Register offsets, field positions and reset values of one timer channel.
// Assumes inclusion by the channel module only; definitions only.
`ifndef TCCH_DEFINES_VH
`define TCCH_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCCH_OFS_CONTROL 8'h00
`define TCCH_OFS_MODE 8'h04
`define TCCH_OFS_COUNTER 8'h10
`define TCCH_OFS_CCA 8'h14
`define TCCH_OFS_CCB 8'h18
`define TCCH_OFS_PERC 8'h1c
`define TCCH_OFS_STATUS 8'h20

// ----------------------------------------------------------------
// Control command bits
// ----------------------------------------------------------------
`define TCCH_CTL_CLKEN 0
`define TCCH_CTL_CLKDIS 1
`define TCCH_CTL_SWTRIG 2

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TCCH_MODE_WAVE 15
`define TCCH_MODE_PERTRG 14
`define TCCH_MODE_EXTTRG_EN 12
`define TCCH_MODE_EVSEL_LO 10
`define TCCH_MODE_EDGE_LO 8
`define TCCH_MODE_TRGSRC_A 10
`define TCCH_MODE_LOADA_LO 16
`define TCCH_MODE_LOADB_LO 18
`define TCCH_MODE_A_MATCH_A 16
`define TCCH_MODE_A_MATCH_C 18
`define TCCH_MODE_A_EXT 20
`define TCCH_MODE_A_SOFT 22
`define TCCH_MODE_B_MATCH_B 24
`define TCCH_MODE_B_MATCH_C 26
`define TCCH_MODE_B_EXT 28
`define TCCH_MODE_B_SOFT 30

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define TCCH_ST_OVF 0
`define TCCH_ST_LOVR 1
`define TCCH_ST_MA 2
`define TCCH_ST_MB 3
`define TCCH_ST_MC 4
`define TCCH_ST_LDA 5
`define TCCH_ST_LDB 6
`define TCCH_ST_ETRG 7
`define TCCH_ST_CLKON 16
`define TCCH_ST_MIRA 17
`define TCCH_ST_MIRB 18

// ----------------------------------------------------------------
// Line action codes, reset values and counter maximum
// ----------------------------------------------------------------
`define TCCH_ACT_NONE 2'h0
`define TCCH_ACT_SET 2'h1
`define TCCH_ACT_CLEAR 2'h2
`define TCCH_ACT_TOGGLE 2'h3
`define TCCH_RST_REG16 16'h0000
`define TCCH_RST_MODE 32'h00000000
`define TCCH_CNT_MAX 16'hffff

`endif

// File: hw/tcch_channel.v
// One 16-bit timer channel: counter, compare/capture registers, status, lines A and B.
// Assumes count_tick_in is a one-cycle pulse on clk_in made by an outside prescaler.
`timescale 1ns/1ps
`include "tcch_defines.vh"

module tcch_channel #(
   parameter WIDTH = 16
) (
   input wire clk_in,
   input wire reset_n_in,
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire count_tick_in,
   input wire ext_event_in,
   input wire line_a_in,
   output wire line_a_out,
   output wire line_a_oe_n_out,
   input wire line_b_in,
   output wire line_b_out,
   output wire line_b_oe_n_out
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function tcch_act;
      input cur;
      input [1:0] code;
      begin
         case (code)
            `TCCH_ACT_SET: tcch_act = 1'b1;
            `TCCH_ACT_CLEAR: tcch_act = 1'b0;
            `TCCH_ACT_TOGGLE: tcch_act = ~cur;
            default: tcch_act = cur;
         endcase
      end
   endfunction

   function tcch_edge;
      input [1:0] sel;
      input rise;
      input fall;
      begin
         tcch_edge = (sel[0] & rise) | (sel[1] & fall);
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; a level counts only once stages two and three agree
   reg [2:0] sa_q, sb_q, se_q;
   reg lvl_a_q, lvl_b_q, lvl_e_q;
   reg lvl_a_d, lvl_b_d, lvl_e_d;

   always @* begin
      lvl_a_d = (sa_q[1] == sa_q[2]) ? sa_q[2] : lvl_a_q;
      lvl_b_d = (sb_q[1] == sb_q[2]) ? sb_q[2] : lvl_b_q;
      lvl_e_d = (se_q[1] == se_q[2]) ? se_q[2] : lvl_e_q;
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sa_q <= 3'h0;
         sb_q <= 3'h0;
         se_q <= 3'h0;
         lvl_a_q <= 1'b0;
         lvl_b_q <= 1'b0;
         lvl_e_q <= 1'b0;
      end else begin
         sa_q <= {sa_q[1:0], line_a_in};
         sb_q <= {sb_q[1:0], line_b_in};
         se_q <= {se_q[1:0], ext_event_in};
         lvl_a_q <= lvl_a_d;
         lvl_b_q <= lvl_b_d;
         lvl_e_q <= lvl_e_d;
      end
   end

   wire rise_a = lvl_a_d & ~lvl_a_q;
   wire fall_a = ~lvl_a_d & lvl_a_q;
   wire rise_b = lvl_b_d & ~lvl_b_q;
   wire fall_b = ~lvl_b_d & lvl_b_q;
   wire rise_e = lvl_e_d & ~lvl_e_q;
   wire fall_e = ~lvl_e_d & lvl_e_q;

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   reg [31:0] mode_q;
   reg [WIDTH-1:0] cnt_q, cca_q, ccb_q, perc_q;
   reg clk_on_q;
   reg [7:0] flags_q;
   reg unread_a_q, unread_b_q;
   reg out_a_q, out_b_q;

   wire wave = mode_q[`TCCH_MODE_WAVE];
   wire wr_ctl = wr_in & (addr_in == `TCCH_OFS_CONTROL);
   wire rd_st = rd_in & (addr_in == `TCCH_OFS_STATUS);
   wire rd_a = rd_in & (addr_in == `TCCH_OFS_CCA);
   wire rd_b = rd_in & (addr_in == `TCCH_OFS_CCB);
   wire sw_trig = wr_ctl & wdata_in[`TCCH_CTL_SWTRIG];
   // Line B is an input in capture mode, and in waveform mode when it is chosen as event source
   wire b_is_input = ~wave | (mode_q[`TCCH_MODE_EVSEL_LO+1:`TCCH_MODE_EVSEL_LO] == 2'h0);

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   wire [1:0] edge_sel = mode_q[`TCCH_MODE_EDGE_LO+1:`TCCH_MODE_EDGE_LO];
   wire cap_trg_a = mode_q[`TCCH_MODE_TRGSRC_A];
   wire ev_src_b = b_is_input;
   wire ext_wave = ev_src_b ? tcch_edge(edge_sel, rise_b, fall_b)
                            : tcch_edge(edge_sel, rise_e, fall_e);
   wire ext_cap = cap_trg_a ? tcch_edge(edge_sel, rise_a, fall_a)
                            : tcch_edge(edge_sel, rise_b, fall_b);
   wire ext_ev = wave ? ext_wave : ext_cap;
   // In waveform mode the event only restarts the counter when enabled
   wire ext_restart = ext_ev & (~wave | mode_q[`TCCH_MODE_EXTTRG_EN]);

   wire tick = count_tick_in & clk_on_q;
   wire wrap = tick & (cnt_q == `TCCH_CNT_MAX);
   wire [WIDTH-1:0] cnt_inc = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
   wire match_a = tick & wave & (cnt_inc == cca_q);
   wire match_b = tick & wave & (cnt_inc == ccb_q);
   wire match_c = tick & (cnt_inc == perc_q);
   wire restart = sw_trig | ext_restart | (match_c & mode_q[`TCCH_MODE_PERTRG]);

   wire load_a = ~wave & tcch_edge(mode_q[`TCCH_MODE_LOADA_LO+1:`TCCH_MODE_LOADA_LO],
                                   rise_a, fall_a);
   wire load_b = ~wave & tcch_edge(mode_q[`TCCH_MODE_LOADB_LO+1:`TCCH_MODE_LOADB_LO],
                                   rise_a, fall_a);
   wire overrun = (load_a & unread_a_q) | (load_b & unread_b_q);

   // ----------------------------------------------------------------
   // Counter and clock state
   // ----------------------------------------------------------------
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= `TCCH_RST_REG16;
         clk_on_q <= 1'b0;
      end else begin
         if (restart)
            cnt_q <= {WIDTH{1'b0}};
         else if (tick)
            cnt_q <= cnt_inc;
         if (wr_ctl & wdata_in[`TCCH_CTL_CLKDIS])
            clk_on_q <= 1'b0;
         else if (restart | (wr_ctl & wdata_in[`TCCH_CTL_CLKEN]))
            clk_on_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mode_q <= `TCCH_RST_MODE;
         cca_q <= `TCCH_RST_REG16;
         ccb_q <= `TCCH_RST_REG16;
         perc_q <= `TCCH_RST_REG16;
         unread_a_q <= 1'b0;
         unread_b_q <= 1'b0;
      end else begin
         if (wr_in & (addr_in == `TCCH_OFS_MODE))
            mode_q <= wdata_in;
         if (load_a)
            cca_q <= cnt_q;
         else if (wr_in & wave & (addr_in == `TCCH_OFS_CCA))
            cca_q <= wdata_in[WIDTH-1:0];
         if (load_b)
            ccb_q <= cnt_q;
         else if (wr_in & wave & (addr_in == `TCCH_OFS_CCB))
            ccb_q <= wdata_in[WIDTH-1:0];
         if (wr_in & (addr_in == `TCCH_OFS_PERC))
            perc_q <= wdata_in[WIDTH-1:0];
         // A load in the read cycle still counts as unread
         unread_a_q <= load_a | (unread_a_q & ~rd_a);
         unread_b_q <= load_b | (unread_b_q & ~rd_b);
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   wire [7:0] ev_now;
   assign ev_now[`TCCH_ST_OVF] = wrap;
   assign ev_now[`TCCH_ST_LOVR] = overrun;
   assign ev_now[`TCCH_ST_MA] = match_a;
   assign ev_now[`TCCH_ST_MB] = match_b;
   assign ev_now[`TCCH_ST_MC] = match_c;
   assign ev_now[`TCCH_ST_LDA] = load_a;
   assign ev_now[`TCCH_ST_LDB] = load_b;
   assign ev_now[`TCCH_ST_ETRG] = ext_ev;

   // Mode-gated view; a mode change hides stale flags of the other mode
   wire [7:0] mode_mask = wave ? 8'h9d : 8'hf3;
   wire [7:0] flags_view = flags_q & mode_mask;

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         flags_q <= 8'h00;
      else if (rd_st)
         flags_q <= ev_now;
      else
         flags_q <= flags_q | ev_now;
   end

   // ----------------------------------------------------------------
   // Line outputs
   // ----------------------------------------------------------------
   // Priority: software trigger, external event, match C, own match
   reg out_a_d, out_b_d;

   always @* begin
      out_a_d = out_a_q;
      out_b_d = out_b_q;
      if (wave) begin
         if (sw_trig) begin
            out_a_d = tcch_act(out_a_q, mode_q[`TCCH_MODE_A_SOFT+1:`TCCH_MODE_A_SOFT]);
            out_b_d = tcch_act(out_b_q, mode_q[`TCCH_MODE_B_SOFT+1:`TCCH_MODE_B_SOFT]);
         end else if (ext_ev) begin
            out_a_d = tcch_act(out_a_q, mode_q[`TCCH_MODE_A_EXT+1:`TCCH_MODE_A_EXT]);
            out_b_d = tcch_act(out_b_q, mode_q[`TCCH_MODE_B_EXT+1:`TCCH_MODE_B_EXT]);
         end else if (match_c) begin
            out_a_d = tcch_act(out_a_q,
                               mode_q[`TCCH_MODE_A_MATCH_C+1:`TCCH_MODE_A_MATCH_C]);
            out_b_d = tcch_act(out_b_q,
                               mode_q[`TCCH_MODE_B_MATCH_C+1:`TCCH_MODE_B_MATCH_C]);
         end else begin
            if (match_a)
               out_a_d = tcch_act(out_a_q,
                                  mode_q[`TCCH_MODE_A_MATCH_A+1:`TCCH_MODE_A_MATCH_A]);
            if (match_b)
               out_b_d = tcch_act(out_b_q,
                                  mode_q[`TCCH_MODE_B_MATCH_B+1:`TCCH_MODE_B_MATCH_B]);
         end
      end
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else begin
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
      end
   end

   assign line_a_out = out_a_q;
   assign line_a_oe_n_out = ~wave;
   assign line_b_out = out_b_q;
   assign line_b_oe_n_out = b_is_input;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   wire mir_a = wave ? out_a_q : lvl_a_q;
   wire mir_b = b_is_input ? lvl_b_q : out_b_q;
   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h00000000;
      case (addr_in)
         `TCCH_OFS_MODE: rd_d = mode_q;
         `TCCH_OFS_COUNTER: rd_d[WIDTH-1:0] = cnt_q;
         `TCCH_OFS_CCA: rd_d[WIDTH-1:0] = cca_q;
         `TCCH_OFS_CCB: rd_d[WIDTH-1:0] = ccb_q;
         `TCCH_OFS_PERC: rd_d[WIDTH-1:0] = perc_q;
         `TCCH_OFS_STATUS: begin
            rd_d[7:0] = flags_view;
            rd_d[`TCCH_ST_CLKON] = clk_on_q;
            rd_d[`TCCH_ST_MIRA] = mir_a;
            rd_d[`TCCH_ST_MIRB] = mir_b;
         end
         default: rd_d = 32'h00000000;
      endcase
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         rdata_out <= 32'h00000000;
      else if (rd_in)
         rdata_out <= rd_d;
      else
         rdata_out <= 32'h00000000;
   end

endmodule // tcch_channel

// File: sim/tcch_channel_asserts.sv
// Port-level checks for the timer channel.
// Assumes the channel's oe_n outputs follow the mode register directly.
`timescale 1ns/1ps
module tcch_channel_chk (
   input wire clk_in,
   input wire reset_n_in,
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [31:0] rdata_out,
   input wire line_a_out,
   input wire line_a_oe_n_out,
   input wire line_b_out,
   input wire line_b_oe_n_out
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside read answer");
   a_value_upper: assert property (rd_in && addr_in inside {8'h10, 8'h14, 8'h18, 8'h1c}
      |=> rdata_out[31:16] == 16'h0) else $error("upper half of value not zero");
   a_status_reserved: assert property (rd_in && addr_in == 8'h20
      |=> rdata_out[31:19] == 13'h0 && rdata_out[15:8] == 8'h0) else $error("status gap set");
   a_oe_a_mode: assert property (wr_in && addr_in == 8'h04
      |=> line_a_oe_n_out == !$past(wdata_in[15])) else $error("line a enable wrong");
   a_oe_b_mode: assert property (wr_in && addr_in == 8'h04
      |=> line_b_oe_n_out == !($past(wdata_in[15]) && $past(wdata_in[11:10]) != 2'h0))
      else $error("line b enable wrong");
   a_oe_changes_only: assert property ($changed(line_a_oe_n_out)
      |-> $past(wr_in && addr_in == 8'h04)) else $error("enable moved without mode write");
   a_wave_flags_only: assert property (rd_in && addr_in == 8'h20 && line_a_oe_n_out
      |=> rdata_out[3:2] == 2'h0) else $error("match flags seen in capture");
   a_capture_flags_only: assert property (rd_in && addr_in == 8'h20 && !line_a_oe_n_out
      |=> rdata_out[6:5] == 2'h0 && !rdata_out[1]) else $error("load flags seen in wave");
   a_mirror_a: assert property (rd_in && addr_in == 8'h20 && !line_a_oe_n_out
      |=> rdata_out[17] == $past(line_a_out)) else $error("line a mirror wrong");
   a_mirror_b: assert property (rd_in && addr_in == 8'h20 && !line_b_oe_n_out
      |=> rdata_out[18] == $past(line_b_out)) else $error("line b mirror wrong");
endmodule // tcch_channel_chk

bind tcch_channel tcch_channel_chk chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .line_a_out(line_a_out), .line_a_oe_n_out(line_a_oe_n_out),
   .line_b_out(line_b_out), .line_b_oe_n_out(line_b_oe_n_out));

// File: sim/tcch_pins.sv
// Far side of lines A and B and of the event pin.
// Assumes the channel drives a line only while its oe_n is low.
`timescale 1ns/1ps
module tcch_pins (
   input wire clk_in,
   input wire drv_a_in,
   input wire oe_a_n_in,
   input wire drv_b_in,
   input wire oe_b_n_in,
   output wire pin_a_out,
   output wire pin_b_out,
   output logic event_out
);
   logic lvl_a = 1'b0;
   logic lvl_b = 1'b0;
   initial event_out = 1'b0;
   // Wire level: channel drive wins while it is enabled
   assign pin_a_out = oe_a_n_in ? lvl_a : drv_a_in;
   assign pin_b_out = oe_b_n_in ? lvl_b : drv_b_in;
   // Hold long enough for the three-stage sync to settle
   task set_pins(input logic a, input logic b, input logic e);
      @(posedge clk_in);
      lvl_a <= a;
      lvl_b <= b;
      event_out <= e;
      repeat (8) @(posedge clk_in);
   endtask
endmodule // tcch_pins

// File: sim/tcch_channel_test.sv
// Self-checking bench for the timer channel.
// Assumes the checker is bound in and the pin model sits on lines A and B.
`timescale 1ns/1ps
module tcch_channel_test;
   logic clk_in, reset_n_in, wr_in, rd_in, count_tick_in;
   logic [7:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   wire ext_event_in, line_a_in, line_b_in, line_a_out, line_b_out;
   wire line_a_oe_n_out, line_b_oe_n_out;
   int fail_count = 0;
   int compares = 0;
   logic [1:0] cd [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
   logic ex [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   tcch_channel tcch_channel_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .count_tick_in(count_tick_in), .ext_event_in(ext_event_in), .line_a_in(line_a_in),
      .line_a_out(line_a_out), .line_a_oe_n_out(line_a_oe_n_out), .line_b_in(line_b_in),
      .line_b_out(line_b_out), .line_b_oe_n_out(line_b_oe_n_out));
   tcch_pins tcch_pins_i (.clk_in(clk_in), .drv_a_in(line_a_out), .oe_a_n_in(line_a_oe_n_out),
      .drv_b_in(line_b_out), .oe_b_n_in(line_b_oe_n_out), .pin_a_out(line_a_in),
      .pin_b_out(line_b_in), .event_out(ext_event_in));
   // ------------------------------------------------------------
   // Bus tasks and compare
   // ------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      compares++;
      if ((got & mask) !== (exp & mask)) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp, mask);
   endtask
   task tick(input int n);
      repeat (n) begin
         @(posedge clk_in);
         count_tick_in <= 1'b1;
         @(posedge clk_in);
         count_tick_in <= 1'b0;
      end
   endtask
   task lines(input logic ea, input logic eb);
      @(posedge clk_in);
      #1;
      chk({30'h0, line_a_out, line_b_out}, {30'h0, ea, eb}, 32'h3);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, reset, watchdog, tests
   // ------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // Longest test is the full counter wrap, about 66k cycles
   initial begin
      #450000;
      fail_count++;
      wrap_up;
   end
   initial begin
      reset_n_in = 1'b0;
      {wr_in, rd_in, count_tick_in} = 3'h0;
      addr_in = 8'h0;
      wdata_in = 32'h0;
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'h10 + 8'(i * 4), 32'h0, '1);
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, 32'h8400 | ({30'h0, cd[i]} << 22) | ({30'h0, cd[i]} << 30));
         wr(8'h00, 32'h4);
         lines(ex[i], ex[i]);
      end
      rd(8'h20, 32'h0007_0000, 32'h0007_0000);
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h5);
      wr(8'h1c, 32'h8);
      rd(8'h14, 32'h3, '1);
      wr(8'h04, 32'h0e06_8400);
      wr(8'h00, 32'h4);
      rd(8'h20, 32'h0007_0000, '1);
      tick(3);
      lines(1'b0, 1'b1);
      tick(2);
      lines(1'b0, 1'b0);
      tick(3);
      lines(1'b1, 1'b1);
      rd(8'h20, 32'h1c, 32'hff);
      rd(8'h20, 32'h0, 32'hff);
      wr(8'h00, 32'h4);
      @(posedge clk_in);
      count_tick_in <= 1'b1;
      repeat (65536) @(posedge clk_in);
      count_tick_in <= 1'b0;
      rd(8'h10, 32'h0, '1);
      rd(8'h20, 32'h1, 32'h1);
      rd(8'h20, 32'h0, 32'h1);
      wr(8'h04, 32'h6070_9500);
      wr(8'h00, 32'h4);
      tick(2);
      rd(8'h20, 32'h0007_0000, '1);
      tcch_pins_i.set_pins(1'b0, 1'b0, 1'b1);
      tcch_pins_i.set_pins(1'b0, 1'b0, 1'b0);
      lines(1'b0, 1'b0);
      rd(8'h10, 32'h0, '1);
      rd(8'h20, 32'h80, 32'h80);
      wr(8'h04, 32'h0009_0000);
      wr(8'h14, 32'h1234);
      rd(8'h14, 32'h3, '1);
      wr(8'h18, 32'h1234);
      rd(8'h18, 32'h5, '1);
      wr(8'h1c, 32'hff);
      rd(8'h1c, 32'hff, '1);
      wr(8'h00, 32'h4);
      wr(8'h10, 32'h55);
      rd(8'h10, 32'h0, '1);
      tick(7);
      rd(8'h20, 32'h0001_0000, '1);
      tcch_pins_i.set_pins(1'b1, 1'b0, 1'b0);
      tcch_pins_i.set_pins(1'b0, 1'b0, 1'b0);
      rd(8'h14, 32'h7, '1);
      rd(8'h18, 32'h7, '1);
      rd(8'h20, 32'h0001_0060, '1);
      tcch_pins_i.set_pins(1'b1, 1'b0, 1'b0);
      tcch_pins_i.set_pins(1'b0, 1'b0, 1'b0);
      tcch_pins_i.set_pins(1'b1, 1'b1, 1'b0);
      rd(8'h20, 32'h0007_0062, '1);
      wr(8'h00, 32'h3);
      rd(8'h20, 32'h0006_0000, '1);
      wr(8'h00, 32'h1);
      rd(8'h20, 32'h0001_0000, 32'h0001_0000);
      wr(8'h04, 32'h0000_4100);
      tcch_pins_i.set_pins(1'b1, 1'b0, 1'b0);
      tcch_pins_i.set_pins(1'b1, 1'b1, 1'b0);
      rd(8'h20, 32'h0007_0080, '1);
      wr(8'h1c, 32'h2);
      tick(2);
      rd(8'h10, 32'h0, '1);
      rd(8'h20, 32'h0007_0010, '1);
      wr(8'h04, 32'h0010_8200);
      tcch_pins_i.set_pins(1'b0, 1'b0, 1'b0);
      lines(1'b1, 1'b0);
      rd(8'h20, 32'h0003_0080, '1);
      rd(8'h30, 32'h0, '1);
      wrap_up;
   end
endmodule // tcch_channel_test
